// ==== tc8_pkg.sv ====
// Constants shared by the 8-bit timer/counter and its prescaler.
// Assumes one system clock at the fc rate; all counts are in fc cycles.
package tc8_pkg;

  // ==========================================================================
  // Register map (byte-wide registers, word index on the address port)
  // ==========================================================================
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_CTRL = 3'h0;   // timer_control_reg
  localparam logic [2:0] ADDR_CMP = 3'h1;    // compare_value_reg
  localparam logic [2:0] ADDR_COUNT = 3'h2;  // live counter value, read only
  localparam logic [2:0] ADDR_GEAR = 3'h3;   // clock_gear_reg

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int CK_LSB = 0;
  localparam int CK_MSB = 2;
  localparam int RUN_BIT = 3;
  localparam int MODE_LSB = 4;
  localparam int MODE_MSB = 5;
  localparam int HALF_BIT = 0;

  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_PDO = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;

  localparam logic [2:0] CK_EVENT_PIN = 3'h7;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'hFF;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  // ==========================================================================
  // Prescaler tick periods, given at a 20 MHz fc with halving off
  // ==========================================================================
  localparam int REF_FC_MHZ = 20;
  localparam int T_000_NS = 102400;
  localparam int T_001_NS = 6400;
  localparam int T_010_NS = 1600;
  localparam int T_011_NS = 400;
  localparam int T_100_NS = 200;
  localparam int T_101_NS = 100;
  localparam int T_110_NS = 50;
  localparam int DIV_000 = T_000_NS * REF_FC_MHZ / 1000;
  localparam int DIV_001 = T_001_NS * REF_FC_MHZ / 1000;
  localparam int DIV_010 = T_010_NS * REF_FC_MHZ / 1000;
  localparam int DIV_011 = T_011_NS * REF_FC_MHZ / 1000;
  localparam int DIV_100 = T_100_NS * REF_FC_MHZ / 1000;
  localparam int DIV_101 = T_101_NS * REF_FC_MHZ / 1000;
  localparam int DIV_110 = T_110_NS * REF_FC_MHZ / 1000;
  localparam int PRESCALE_W = $clog2(DIV_000) + 1;

  // Log2 of the fc division for a clock-select code; halving adds one.
  function automatic int div_shift(input logic [2:0] sel, input logic half);
    int s;
    s = 0;
    unique case (sel)
      3'h0: s = $clog2(DIV_000);
      3'h1: s = $clog2(DIV_001);
      3'h2: s = $clog2(DIV_010);
      3'h3: s = $clog2(DIV_011);
      3'h4: s = $clog2(DIV_100);
      3'h5: s = $clog2(DIV_101);
      3'h6: s = $clog2(DIV_110);
      3'h7: s = 0;
    endcase
    return s + (half ? 1 : 0);
  endfunction

endpackage

// ==== tc8_tick_if.sv ====
// Carrier between the timer core and its prescaler.
// Assumes both ends sit on the same system clock.
`timescale 1ns/10ps
`default_nettype none
interface tc8_tick_if;
  logic [2:0] sel;
  logic half;
  logic tick;
  modport core (output sel, output half, input tick);
  modport pre (input sel, input half, output tick);
endinterface
`default_nettype wire

// ==== tc8_prescaler.sv ====
// Free-running prescaler producing a one-cycle tick enable for the timer.
// Assumes a synchronous active-high reset on the system clock.
`timescale 1ns/10ps
`default_nettype none
module tc8_prescaler #(
  parameter int PW = tc8_pkg::PRESCALE_W
) (
  input wire logic ref_clk,  // system clock
  input wire logic rst,      // synchronous reset
  tc8_tick_if.pre tk         // select in, tick out
);

  logic [PW-1:0] div_q;
  logic [PW-1:0] mask;

  // ==========================================================================
  // Divider
  // ==========================================================================
  // The divider never restarts, so the first tick after start may come early.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + PW'(1);
    end
  end

  always_comb begin
    mask = PW'((1 << tc8_pkg::div_shift(tk.sel, tk.half)) - 1);
  end

  assign tk.tick = ((div_q & mask) == mask);

endmodule
`default_nettype wire

// ==== tc8_timer.sv ====
// 8-bit timer/counter top: timer, event counter, divider output and PWM.
// Assumes a register master on the plain port and synchronous pin inputs.
//
// Function
// - Timer mode counts ticks; match interrupts, clears and counting goes on.
// - Event mode counts pin rises; match is judged and cleared at falls.
// - Divider mode toggles its pin on every match, interrupts and clears.
// - Divider pin is high whenever the timer is stopped.
// - PWM pin goes low at shadow match, high with interrupt at overflow.
// - PWM pin is high whenever the timer is stopped.
// - PWM shadow reloads at period end, and first at start.
// - Entering STOP clears the run bit.
// - Control register bits 6 and 7 have no storage and read as zero.
// - Event and PWM modes only work in NORMAL and IDLE states.
// - Tick periods follow the clock-select table, doubled when halving.
// - PWM resolution is eight bits from an internal tick.
`timescale 1ns/10ps
`default_nettype none
module tc8_timer (
  input wire logic ref_clk,                       // system clock, fc
  input wire logic rst,                           // synchronous reset, high
  input wire logic [tc8_pkg::ADDR_W-1:0] reg_addr, // register index
  input wire logic [7:0] reg_wdata,               // write data
  input wire logic reg_we,                        // write strobe
  input wire logic reg_re,                        // read strobe
  output logic [7:0] reg_rdata,                   // read data, cycle after read
  input wire logic stop_enter,                    // pulse: STOP state entered
  input wire logic slow_state,                    // high outside NORMAL/IDLE
  input wire logic event_input_pin,               // external count input
  output logic divider_out_pin,                   // divider square wave
  output logic pwm_out_pin_n,                     // PWM output, active low
  output logic timer_match_irq                    // interrupt pulse
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic run_q;
  logic run_dly_q;
  logic [1:0] mode_q;
  logic [2:0] ck_q;
  logic half_q;
  logic [7:0] cmp_q;
  logic [7:0] shadow_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_inc;
  logic ev_s1_q;
  logic ev_s2_q;
  logic ev_s3_q;
  logic ev_rise;
  logic ev_fall;
  logic active;
  logic low_ok;
  logic tmr_match;
  logic ev_match;
  logic pwm_hit;
  logic pwm_ovf;
  logic [7:0] rdata_q;
  logic pdo_q;
  logic pwm_n_q;
  logic irq_q;

  tc8_tick_if tk ();

  assign tk.sel = ck_q;
  assign tk.half = half_q;

  tc8_prescaler u_pre (
    .ref_clk(ref_clk),
    .rst(rst),
    .tk(tk)
  );

  wire ctrl_wr = reg_we && (reg_addr == tc8_pkg::ADDR_CTRL);

  // STOP entry wins over a coincident software write.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_q <= tc8_pkg::CTRL_RESET[tc8_pkg::RUN_BIT];
    end else if (stop_enter) begin
      run_q <= 1'b0;
    end else if (ctrl_wr) begin
      run_q <= reg_wdata[tc8_pkg::RUN_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q <= tc8_pkg::CTRL_RESET[tc8_pkg::MODE_MSB:tc8_pkg::MODE_LSB];
      ck_q <= tc8_pkg::CTRL_RESET[tc8_pkg::CK_MSB:tc8_pkg::CK_LSB];
    end else if (ctrl_wr) begin
      mode_q <= reg_wdata[tc8_pkg::MODE_MSB:tc8_pkg::MODE_LSB];
      ck_q <= reg_wdata[tc8_pkg::CK_MSB:tc8_pkg::CK_LSB];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      half_q <= 1'b0;
    end else if (reg_we && (reg_addr == tc8_pkg::ADDR_GEAR)) begin
      half_q <= reg_wdata[tc8_pkg::HALF_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmp_q <= tc8_pkg::CMP_RESET;
    end else if (reg_we && (reg_addr == tc8_pkg::ADDR_CMP)) begin
      cmp_q <= reg_wdata;
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  // Bits 6 and 7 of control have no storage; they read as zero.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_re) begin
      unique case (reg_addr)
        tc8_pkg::ADDR_CTRL: rdata_q <= {2'h0, mode_q, run_q, ck_q};
        tc8_pkg::ADDR_CMP: rdata_q <= cmp_q;
        tc8_pkg::ADDR_COUNT: rdata_q <= cnt_q;
        tc8_pkg::ADDR_GEAR: rdata_q <= {7'h00, half_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ==========================================================================
  // Event pin synchroniser and edge detect
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
    end else begin
      ev_s1_q <= event_input_pin;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end

  // Pulses shorter than the synchroniser can resolve are lost; the pin
  // source must keep each phase several clocks long.
  assign ev_rise = ev_s2_q && !ev_s3_q;
  assign ev_fall = !ev_s2_q && ev_s3_q;

  // ==========================================================================
  // Counter and match detection
  // ==========================================================================
  // The first running cycle only loads the PWM shadow, so counting starts
  // one clock after the run bit rises.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_dly_q <= 1'b0;
    end else begin
      run_dly_q <= run_q;
    end
  end

  assign active = run_q && run_dly_q;
  assign low_ok = !slow_state;
  assign cnt_inc = cnt_q + 8'h01;

  assign tmr_match = active && tk.tick && (cnt_inc == cmp_q)
                     && ((mode_q == tc8_pkg::MODE_TIMER) || (mode_q == tc8_pkg::MODE_PDO));
  assign ev_match = active && low_ok && (mode_q == tc8_pkg::MODE_EVENT)
                    && ev_fall && (cnt_q == cmp_q);
  assign pwm_ovf = active && low_ok && (mode_q == tc8_pkg::MODE_PWM)
                   && tk.tick && (cnt_q == tc8_pkg::COUNT_MAX);
  assign pwm_hit = active && low_ok && (mode_q == tc8_pkg::MODE_PWM)
                   && tk.tick && (cnt_inc == shadow_q);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else if (!active) begin
      cnt_q <= 8'h00;
    end else begin
      unique case (mode_q)
        tc8_pkg::MODE_TIMER, tc8_pkg::MODE_PDO: begin
          if (tmr_match) begin
            cnt_q <= 8'h00;
          end else if (tk.tick) begin
            cnt_q <= cnt_inc;
          end
        end
        tc8_pkg::MODE_EVENT: begin
          if (low_ok && ev_rise) begin
            cnt_q <= cnt_inc;
          end else if (ev_match) begin
            cnt_q <= 8'h00;
          end
        end
        tc8_pkg::MODE_PWM: begin
          if (low_ok && tk.tick) begin
            cnt_q <= cnt_inc;
          end
        end
      endcase
    end
  end

  // A compare write landing with the period end misses that reload; the
  // shadow keeps the old value and the new one waits for the next period end.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shadow_q <= tc8_pkg::CMP_RESET;
    end else if (run_q && !run_dly_q) begin
      shadow_q <= cmp_q;
    end else if (pwm_ovf) begin
      shadow_q <= cmp_q;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= tmr_match || ev_match || pwm_ovf;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pdo_q <= 1'b1;
    end else if (!run_q) begin
      pdo_q <= 1'b1;
    end else if (tmr_match && (mode_q == tc8_pkg::MODE_PDO)) begin
      pdo_q <= !pdo_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwm_n_q <= 1'b1;
    end else if (!run_q) begin
      pwm_n_q <= 1'b1;
    end else if (pwm_ovf) begin
      pwm_n_q <= 1'b1;
    end else if (pwm_hit) begin
      pwm_n_q <= 1'b0;
    end
  end

  assign reg_rdata = rdata_q;
  assign divider_out_pin = pdo_q;
  assign pwm_out_pin_n = pwm_n_q;
  assign timer_match_irq = irq_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_timer_match;
    @(posedge ref_clk) disable iff (rst)
      (tmr_match && mode_q == tc8_pkg::MODE_TIMER) |=> (cnt_q == 8'h00) && timer_match_irq;
  endproperty
  a_timer_match: assert property (p_timer_match) else $error("timer match missed");

  property p_event_fall;
    @(posedge ref_clk) disable iff (rst)
      ev_match |=> (cnt_q == 8'h00) && timer_match_irq;
  endproperty
  a_event_fall: assert property (p_event_fall) else $error("event match missed");

  property p_event_rise;
    @(posedge ref_clk) disable iff (rst)
      (active && low_ok && mode_q == tc8_pkg::MODE_EVENT && ev_rise)
        |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_event_rise: assert property (p_event_rise) else $error("event rise not counted");

  property p_pdo_toggle;
    @(posedge ref_clk) disable iff (rst)
      (tmr_match && mode_q == tc8_pkg::MODE_PDO && !stop_enter && !ctrl_wr)
        |=> (divider_out_pin != $past(divider_out_pin)) && timer_match_irq;
  endproperty
  a_pdo_toggle: assert property (p_pdo_toggle) else $error("divider did not toggle");

  property p_pdo_stop;
    @(posedge ref_clk) disable iff (rst)
      !run_q |=> divider_out_pin;
  endproperty
  a_pdo_stop: assert property (p_pdo_stop) else $error("divider low while stopped");

  property p_pwm_low;
    @(posedge ref_clk) disable iff (rst)
      (pwm_hit && !pwm_ovf && run_q && !stop_enter && !ctrl_wr) |=> !pwm_out_pin_n;
  endproperty
  a_pwm_low: assert property (p_pwm_low) else $error("pwm did not go low");

  property p_pwm_ovf;
    @(posedge ref_clk) disable iff (rst)
      pwm_ovf |=> pwm_out_pin_n && timer_match_irq && (cnt_q == 8'h00);
  endproperty
  a_pwm_ovf: assert property (p_pwm_ovf) else $error("pwm overflow missed");

  property p_pwm_stop;
    @(posedge ref_clk) disable iff (rst)
      !run_q |=> pwm_out_pin_n;
  endproperty
  a_pwm_stop: assert property (p_pwm_stop) else $error("pwm low while stopped");

  property p_shadow_load;
    @(posedge ref_clk) disable iff (rst)
      (run_q && !run_dly_q) |=> shadow_q == $past(cmp_q);
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded");

  property p_stop_clear;
    @(posedge ref_clk) disable iff (rst)
      stop_enter |=> !run_q ##1 divider_out_pin && pwm_out_pin_n;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear run");

  property p_ctrl_top_bits;
    @(posedge ref_clk) disable iff (rst)
      (reg_re && reg_addr == tc8_pkg::ADDR_CTRL) |=> reg_rdata[7:6] == 2'h0;
  endproperty
  a_ctrl_top_bits: assert property (p_ctrl_top_bits) else $error("ctrl top bits set");

  property p_slow_hold;
    @(posedge ref_clk) disable iff (rst)
      (slow_state && active && mode_q == tc8_pkg::MODE_PWM) |=> cnt_q == $past(cnt_q);
  endproperty
  a_slow_hold: assert property (p_slow_hold) else $error("pwm ran in slow state");

endmodule
`default_nettype wire

// ==== tc8_event_src.sv ====
// Behavioural pulse source that drives the event input pin of the timer.
// Assumes the timer's system clock; one burst runs at a time, pin idles low.
`timescale 1ns/10ps
`default_nettype none
module tc8_event_src #(
  parameter int MIN_PHASE = 3
) (
  input wire logic ref_clk,      // system clock
  input wire logic rst,          // synchronous reset, high
  input wire logic start,        // pulse: begin a burst
  input wire logic [7:0] pulses, // rising edges in the burst
  input wire logic [7:0] phase,  // cycles per high or low phase
  output logic pin,              // event input drive
  output logic busy              // high while a burst runs
);
  // ====================
  // Burst generator
  // ====================
  logic [8:0] left_q;
  logic [7:0] ph_q;
  logic [7:0] ph_len;
  // Short phases are stretched, since the counter cannot see narrower ones.
  assign ph_len = (phase < 8'(MIN_PHASE)) ? 8'(MIN_PHASE) : phase;
  assign busy = (left_q != 9'h000);
  always @(posedge ref_clk) begin
    if (rst) begin
      pin <= 1'b0;
      left_q <= 9'h000;
      ph_q <= 8'h00;
    end else if (start && !busy) begin
      left_q <= {pulses, 1'b0};
      ph_q <= ph_len;
    end else if (busy) begin
      if (ph_q <= 8'h01) begin
        pin <= ~pin;
        left_q <= left_q - 9'h001;
        ph_q <= ph_len;
      end else begin
        ph_q <= ph_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the 8-bit timer/counter.
// Assumes the timer top and the event pulse source compile beforehand.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk, rst, reg_we, reg_re, stop_enter, slow_state;
  logic [tc8_pkg::ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, src_pulses, src_phase;
  logic ev_pin, div_pin, pwm_n, irq, src_start, src_busy, rd_d, pwm_l, div_l;
  logic [15:0] n_irq, n_low, n_div;
  logic [15:0] div_tab [4];
  logic [7:0] rq[$];
  logic [15:0] iq[$], pq[$], dq[$];
  logic [31:0] lfsr_q;
  int errors, cmp_count;

  tc8_timer dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .stop_enter(stop_enter),
    .slow_state(slow_state), .event_input_pin(ev_pin), .divider_out_pin(div_pin),
    .pwm_out_pin_n(pwm_n), .timer_match_irq(irq));
  tc8_event_src src (.ref_clk(ref_clk), .rst(rst), .start(src_start), .pulses(src_pulses),
    .phase(src_phase), .pin(ev_pin), .busy(src_busy));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ====================
  // Helpers
  // ====================
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One bus cycle; exactly one strobe is high, chosen by we.
  task automatic acc(input logic we, input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= we;
    reg_re <= !we;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    rq.push_back(exp);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic idle();
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Waits for n interrupt pulses, then one edge more so a note pushed next
  // cannot be taken by the pulse just seen.
  task automatic wait_irq(input int n);
    int k;
    k = 0;
    while (n > 0) begin
      @(posedge ref_clk);
      k++;
      if (irq === 1'b1) n--;
      if (k > 20000) begin
        errors++;
        $display("ERROR irq wait expected pulse seen none");
        finish_test();
      end
    end
    @(posedge ref_clk);
  endtask
  task automatic wait_for(input int sel);
    int k;
    for (k = 0; k < 5000; k++) begin
      if (sel == 0 ? pwm_n === 1'b0 : src_busy === 1'b0) break;
      @(posedge ref_clk);
    end
    if (k == 5000) begin
      errors++;
      $display("ERROR level wait expected change seen none");
      finish_test();
    end
  endtask

  // ====================
  // Output monitor
  // ====================
  always @(posedge ref_clk) begin
    if (rst) begin
      rd_d <= 1'b0;
      pwm_l <= 1'b1;
      div_l <= 1'b1;
      n_irq <= 16'h0000;
      n_low <= 16'h0000;
      n_div <= 16'h0000;
    end else begin
      rd_d <= reg_re;
      if (rd_d) check("read data", {8'h00, rq.pop_front()}, {8'h00, reg_rdata});
      else check("idle read data", 16'h0000, {8'h00, reg_rdata});
      n_irq <= (irq === 1'b1) ? 16'h0001 : n_irq + 16'h0001;
      if (irq === 1'b1 && iq.size() > 0) check("irq gap", iq.pop_front(), n_irq);
      pwm_l <= pwm_n;
      div_l <= div_pin;
      n_low <= (pwm_n === 1'b0) ? n_low + 16'h0001 : 16'h0000;
      if (pwm_n === 1'b1 && pwm_l === 1'b0 && pq.size() > 0) check("pwm low", pq.pop_front(), n_low);
      n_div <= (div_pin !== div_l) ? 16'h0001 : n_div + 16'h0001;
      if (div_pin !== div_l && dq.size() > 0) check("divider half", dq.pop_front(), n_div);
    end
  end

  // ====================
  // Main sequence
  // ====================
  initial begin
    logic [2:0] ck;
    logic [7:0] cmp;
    logic half;
    int hits;
    logic [7:0] pl;
    logic [7:0] ph;
    int evc;
    errors = 0;
    cmp_count = 0;
    lfsr_q = 32'h0000EDC8;
    div_tab = '{16'(tc8_pkg::DIV_000), 16'(tc8_pkg::DIV_001), 16'(tc8_pkg::DIV_010),
      16'(tc8_pkg::DIV_011)};
    {rst, reg_we, reg_re, stop_enter, slow_state, src_start} = 6'h20;
    {reg_addr, reg_wdata, src_pulses, src_phase} = '0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(tc8_pkg::ADDR_CTRL, tc8_pkg::CTRL_RESET);
    rd(tc8_pkg::ADDR_CMP, tc8_pkg::CMP_RESET);
    rd(3'h4, 8'h00);
    wr(tc8_pkg::ADDR_CTRL, 8'hC2);
    wr(3'h5, 8'h55);
    wr(tc8_pkg::ADDR_COUNT, 8'h33);
    rd(tc8_pkg::ADDR_CTRL, 8'h02);
    rd(3'h5, 8'h00);
    rd(tc8_pkg::ADDR_COUNT, 8'h00);
    idle();
    check("divider idle", 16'h0001, {15'h0000, div_pin});
    check("pwm idle", 16'h0001, {15'h0000, pwm_n});
    // Timer periods for clock codes 0 to 3, then two random compares on code 3, the second with halving.
    for (int k = 0; k < 6; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      ck = (k < 4) ? 3'(k) : 3'h3;
      cmp = (k < 4) ? 8'h02 : 8'(lfsr_q % 255) + 8'h01;
      half = (k == 5) ? 1'b1 : lfsr_q[9] & (k > 3);
      wr(tc8_pkg::ADDR_GEAR, {7'h00, half});
      wr(tc8_pkg::ADDR_CMP, cmp);
      wr(tc8_pkg::ADDR_CTRL, {5'h00, ck});
      wr(tc8_pkg::ADDR_CTRL, {5'h01, ck});
      idle();
      wait_irq(1);
      iq.push_back((16'(cmp) * div_tab[ck[1:0]]) << half);
      wait_irq(1);
      wr(tc8_pkg::ADDR_CTRL, {5'h00, ck});
      idle();
      rd(tc8_pkg::ADDR_COUNT, 8'h00);
      idle();
    end
    // Divider: square wave, then STOP entry while the pin is low.
    wr(tc8_pkg::ADDR_GEAR, 8'h00);
    wr(tc8_pkg::ADDR_CMP, 8'h03);
    wr(tc8_pkg::ADDR_CTRL, 8'h22);
    wr(tc8_pkg::ADDR_CTRL, 8'h2A);
    idle();
    wait_irq(1);
    dq.push_back(16'd96);
    dq.push_back(16'd96);
    iq.push_back(16'd96);
    wait_irq(2);
    check("divider level", 16'h0000, {15'h0000, div_pin});
    stop_enter <= 1'b1;
    @(posedge ref_clk);
    stop_enter <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    check("divider stopped", 16'h0001, {15'h0000, div_pin});
    rd(tc8_pkg::ADDR_CTRL, 8'h22);
    // PWM: first value loaded at start, later write waits for period end.
    wr(tc8_pkg::ADDR_CMP, 8'h40);
    wr(tc8_pkg::ADDR_CTRL, 8'h35);
    pq.push_back(16'd384);
    wr(tc8_pkg::ADDR_CTRL, 8'h3D);
    idle();
    wait_irq(1);
    wr(tc8_pkg::ADDR_CMP, 8'hC0);
    idle();
    pq.push_back(16'd384);
    pq.push_back(16'd128);
    iq.push_back(16'd512);
    wait_irq(2);
    pq.push_back(16'd128);
    slow_state <= 1'b1;
    hits = 0;
    repeat (600) begin
      @(posedge ref_clk);
      if (irq === 1'b1) hits++;
    end
    slow_state <= 1'b0;
    check("irq while frozen", 16'h0000, 16'(hits));
    wait_irq(1);
    wait_for(0);
    wr(tc8_pkg::ADDR_CTRL, 8'h35);
    idle();
    repeat (2) @(posedge ref_clk);
    #1;
    check("pwm stopped", 16'h0001, {15'h0000, pwm_n});
    // Event counting with random bursts; the count carries across bursts.
    // At least six pulses per burst give two matches, so one gap is timed.
    wr(tc8_pkg::ADDR_CMP, 8'h03);
    wr(tc8_pkg::ADDR_CTRL, 8'h17);
    wr(tc8_pkg::ADDR_CTRL, 8'h1F);
    idle();
    evc = 0;
    for (int k = 0; k < 2; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      pl = 8'h06 + 8'(lfsr_q[1:0]);
      ph = 8'h03 + 8'(lfsr_q[4:2]);
      src_pulses <= pl;
      src_phase <= ph;
      src_start <= 1'b1;
      @(posedge ref_clk);
      src_start <= 1'b0;
      wait_irq(1);
      iq.push_back(16'(ph) * 16'h0006);
      wait_irq(1);
      wait_for(1);
      repeat (6) @(posedge ref_clk);
      evc = (evc + int'(pl)) % 3;
      rd(tc8_pkg::ADDR_COUNT, 8'(evc));
      idle();
    end
    repeat (4) @(posedge ref_clk);
    finish_test();
  end
endmodule
`default_nettype wire
